/* File: common/ddc_chan_pkg.sv */
`default_nettype none
package ddc_chan_pkg;
   localparam logic [2:0] EXT_DATA_LOW = 3'h0;
   localparam logic [2:0] EXT_DATA_MID = 3'h1;
   localparam logic [2:0] EXT_DATA_TOP = 3'h2;
   localparam logic [2:0] EXT_SLEEP_CTL = 3'h3;
   localparam logic [2:0] EXT_PIN_SYNC = 3'h4;
   localparam logic [2:0] EXT_SOFT_SYNC = 3'h5;
   localparam logic [2:0] EXT_CHAN_ADDR = 3'h6;
   localparam logic [2:0] EXT_ACCESS_CTL = 3'h7;
   localparam int ACR_AUTOINC_BIT = 7;
   localparam int SLEEP_PORTMAP_BIT = 5;
   localparam int SOFT_START_BIT = 4;
   localparam int SOFT_HOP_BIT = 5;
   localparam int PIN_START_BIT = 4;
   localparam int PIN_HOP_BIT = 5;
   localparam int PIN_FIRST_BIT = 6;
   localparam int TOP_BITS = 4;
   localparam logic [7:0] COEFFICIENT_MEMORY_LAST = 8'h7f;
   localparam logic [7:0] A_SLEEP = 8'h80;
   localparam logic [7:0] A_SOFT = 8'h81;
   localparam logic [7:0] A_PIN = 8'h82;
   localparam logic [7:0] A_START_HO = 8'h83;
   localparam logic [7:0] A_HOP_HO = 8'h84;
   localparam logic [7:0] A_FREQ_LO = 8'h85;
   localparam logic [7:0] A_FREQ_HI = 8'h86;
   localparam logic [7:0] A_PHASE = 8'h87;
   localparam logic [7:0] A_OSC_CTL = 8'h88;
   localparam logic [7:0] A_RS_DEC = 8'h90;
   localparam logic [7:0] A_RS_INT = 8'h91;
   localparam logic [7:0] A_RS_SCALE = 8'h92;
   localparam logic [7:0] A_RSVD_A = 8'h93;
   localparam logic [7:0] A_C5_DEC = 8'h94;
   localparam logic [7:0] A_C5_SCALE = 8'h95;
   localparam logic [7:0] A_RSVD_B = 8'h96;
   localparam logic [7:0] A_CF_DEC = 8'ha0;
   localparam logic [7:0] A_CF_PHASE = 8'ha1;
   localparam logic [7:0] A_CF_TAPS = 8'ha2;
   localparam logic [7:0] A_CF_OFS = 8'ha3;
   localparam logic [7:0] A_CF_CTL = 8'ha4;
   localparam int CF_CTL_BANK_BIT = 8;
   localparam int OSC_CLR_BIT = 3;
   localparam int OSC_SEL_LO = 7;
   localparam int MAX_TAPS = 160;
   localparam logic [15:0] HO_ONE = 16'h0001;
   localparam logic [15:0] HO_ZERO = 16'h0000;
   typedef struct packed {
      logic [1:0] pin_sel;
      logic port_b;
      logic [1:0] rsvd;
      logic clr_on_hop;
      logic amp_dither;
      logic phase_dither;
      logic bypass;
   } osc_ctl_t;
   typedef struct packed {
      logic first_only;
      logic hop_en;
      logic start_en;
   } pin_sync_t;
   typedef struct packed {
      logic [31:0] freq;
      logic [15:0] phase;
      osc_ctl_t ctl;
      logic load_freq;
      logic clr_acc;
   } osc_out_t;
endpackage : ddc_chan_pkg
`default_nettype wire

/* File: design/holdoff_counter.sv */
`default_nettype none
module holdoff_counter (
   input wire logic mclk,
   input wire logic rst,
   input wire logic trig,
   input wire logic [15:0] load_val,
   output logic fire,
   output logic busy
);
   logic [15:0] cnt_r;
   // Value zero ignores triggers, one fires at once
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_r <= 16'h0000;
         fire <= 1'b0;
      end else begin
         fire <= 1'b0;
         if (trig && load_val != ddc_chan_pkg::HO_ZERO) begin
            if (load_val == ddc_chan_pkg::HO_ONE) begin
               fire <= 1'b1;
               cnt_r <= 16'h0000;
            end else begin
               cnt_r <= load_val - 16'h0001;
            end
         end else if (cnt_r != 16'h0000) begin
            if (cnt_r == ddc_chan_pkg::HO_ONE)
               fire <= 1'b1;
            cnt_r <= cnt_r - 16'h0001;
         end
      end
   end
   assign busy = cnt_r != 16'h0000;

   a_zero_ignores: assert property (@(posedge mclk) disable iff (rst)
      trig && load_val == ddc_chan_pkg::HO_ZERO && !busy |=> !fire)
      else $error("zero hold-off fired");
   a_one_immediate: assert property (@(posedge mclk) disable iff (rst)
      trig && load_val == ddc_chan_pkg::HO_ONE |=> fire)
      else $error("hold-off one did not fire at once");
   a_two_delay: assert property (@(posedge mclk) disable iff (rst)
      trig && load_val == 16'h0002 ##1 !trig |=> fire)
      else $error("hold-off two timing wrong");
endmodule : holdoff_counter
`default_nettype wire

/* File: design/ddc_channel_sync_control.sv */
`default_nettype none
module ddc_channel_sync_control #(
   parameter int COEFFICIENT_MEMORY_WORDS = 128,
   parameter int WORD_W = 20
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [2:0] ext_addr,
   input wire logic [7:0] ext_wdata,
   input wire logic ext_wr,
   input wire logic ext_rd,
   output logic [7:0] ext_rdata,
   input wire logic [3:0] sync_pins,
   output logic channel_sleep,
   output logic realign,
   output logic portmap_access,
   output ddc_chan_pkg::osc_out_t osc,
   output logic [11:0] rs_dec_m1,
   output logic [8:0] rs_int_m1,
   output logic [11:0] rs_scale,
   output logic [7:0] c5_dec_m1,
   output logic [4:0] c5_scale,
   output logic [7:0] cf_dec_m1,
   output logic [7:0] cf_phase,
   output logic [7:0] cf_taps_m1,
   output logic [7:0] cf_offset,
   output logic [10:0] cf_ctl
);
   logic [7:0] dr_mid_r, dr_top_r, acr_r, car_r, sleep_ctl_r;
   logic [WORD_W-1:0] rd_word_r;
   logic [WORD_W-1:0] coefficient_memory_r [2*COEFFICIENT_MEMORY_WORDS];
   logic [15:0] start_ho_r, hop_ho_r, freq_lo_r, freq_hi_r, phase_r;
   ddc_chan_pkg::osc_ctl_t osc_ctl_r;
   ddc_chan_pkg::pin_sync_t pin_r;
   logic sleep_r, first_seen_r;
   logic [31:0] freq_work_r;
   logic [WORD_W-1:0] wword;
   logic wr_low, rd_low, int_wr, soft_start, soft_hop, pin_pulse, pin_start, pin_hop;
   logic start_fire, hop_fire, start_busy, hop_busy, wake;
   logic [7:0] ia;
   logic [7:0] cm_idx;

   assign wword = {dr_top_r[ddc_chan_pkg::TOP_BITS-1:0], dr_mid_r, ext_wdata};
   assign wr_low = ext_wr && ext_addr == ddc_chan_pkg::EXT_DATA_LOW;
   assign rd_low = ext_rd && ext_addr == ddc_chan_pkg::EXT_DATA_LOW;
   assign ia = car_r;
   assign int_wr = wr_low && !sleep_ctl_r[ddc_chan_pkg::SLEEP_PORTMAP_BIT];
   assign cm_idx = {cf_ctl[ddc_chan_pkg::CF_CTL_BANK_BIT], ia[6:0]};

   // External registers and pointer
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dr_mid_r <= 8'h00;
         dr_top_r <= 8'h00;
         acr_r <= 8'h00;
         car_r <= 8'h00;
         sleep_ctl_r <= 8'h00;
      end else begin
         if (ext_wr) begin
            unique case (ext_addr)
               ddc_chan_pkg::EXT_DATA_MID: dr_mid_r <= ext_wdata;
               ddc_chan_pkg::EXT_DATA_TOP: dr_top_r <= {4'h0, ext_wdata[3:0]};
               ddc_chan_pkg::EXT_SLEEP_CTL: sleep_ctl_r <= ext_wdata;
               ddc_chan_pkg::EXT_CHAN_ADDR: car_r <= ext_wdata;
               ddc_chan_pkg::EXT_ACCESS_CTL: acr_r <= ext_wdata;
               default: ;
            endcase
         end
         if ((wr_low || rd_low) && acr_r[ddc_chan_pkg::ACR_AUTOINC_BIT])
            car_r <= car_r + 8'h01;
      end
   end

   // Coefficient memory, two banks shared by I and Q
   always_ff @(posedge mclk) begin
      if (int_wr && ia <= ddc_chan_pkg::COEFFICIENT_MEMORY_LAST)
         coefficient_memory_r[cm_idx] <= wword;
   end

   // Read fetch starts on low data read
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rd_word_r <= '0;
         ext_rdata <= 8'h00;
      end else begin
         if (rd_low) begin
            if (ia <= ddc_chan_pkg::COEFFICIENT_MEMORY_LAST)
               rd_word_r <= coefficient_memory_r[cm_idx];
            else
               unique case (ia)
                  ddc_chan_pkg::A_SLEEP: rd_word_r <= {19'h0, sleep_r};
                  ddc_chan_pkg::A_PIN: rd_word_r <= {17'h0, pin_r};
                  ddc_chan_pkg::A_START_HO: rd_word_r <= {4'h0, start_ho_r};
                  ddc_chan_pkg::A_HOP_HO: rd_word_r <= {4'h0, hop_ho_r};
                  ddc_chan_pkg::A_FREQ_LO: rd_word_r <= {4'h0, freq_lo_r};
                  ddc_chan_pkg::A_FREQ_HI: rd_word_r <= {4'h0, freq_hi_r};
                  ddc_chan_pkg::A_PHASE: rd_word_r <= {4'h0, phase_r};
                  ddc_chan_pkg::A_OSC_CTL: rd_word_r <= {11'h0, osc_ctl_r};
                  ddc_chan_pkg::A_RS_DEC: rd_word_r <= {8'h0, rs_dec_m1};
                  ddc_chan_pkg::A_RS_INT: rd_word_r <= {11'h0, rs_int_m1};
                  ddc_chan_pkg::A_RS_SCALE: rd_word_r <= {8'h0, rs_scale};
                  ddc_chan_pkg::A_C5_DEC: rd_word_r <= {12'h0, c5_dec_m1};
                  ddc_chan_pkg::A_C5_SCALE: rd_word_r <= {15'h0, c5_scale};
                  ddc_chan_pkg::A_CF_DEC: rd_word_r <= {12'h0, cf_dec_m1};
                  ddc_chan_pkg::A_CF_PHASE: rd_word_r <= {12'h0, cf_phase};
                  ddc_chan_pkg::A_CF_TAPS: rd_word_r <= {12'h0, cf_taps_m1};
                  ddc_chan_pkg::A_CF_OFS: rd_word_r <= {12'h0, cf_offset};
                  ddc_chan_pkg::A_CF_CTL: rd_word_r <= {9'h0, cf_ctl};
                  default: rd_word_r <= '0;
               endcase
         end
         if (ext_rd) begin
            unique case (ext_addr)
               ddc_chan_pkg::EXT_DATA_LOW: ext_rdata <= 8'h00;
               ddc_chan_pkg::EXT_DATA_MID: ext_rdata <= rd_word_r[15:8];
               ddc_chan_pkg::EXT_DATA_TOP: ext_rdata <= {4'h0, rd_word_r[19:16]};
               ddc_chan_pkg::EXT_CHAN_ADDR: ext_rdata <= car_r;
               ddc_chan_pkg::EXT_ACCESS_CTL: ext_rdata <= acr_r;
               default: ext_rdata <= 8'h00;
            endcase
         end
      end
   end

   // Channel configuration storage, values minus one as written
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         start_ho_r <= 16'h0000;
         hop_ho_r <= 16'h0000;
         freq_lo_r <= 16'h0000;
         freq_hi_r <= 16'h0000;
         phase_r <= 16'h0000;
         osc_ctl_r <= '0;
         rs_dec_m1 <= 12'h000;
         rs_int_m1 <= 9'h000;
         rs_scale <= 12'h000;
         c5_dec_m1 <= 8'h00;
         c5_scale <= 5'h00;
         cf_dec_m1 <= 8'h00;
         cf_phase <= 8'h00;
         cf_taps_m1 <= 8'h00;
         cf_offset <= 8'h00;
         cf_ctl <= 11'h000;
      end else if (int_wr) begin
         unique case (ia)
            ddc_chan_pkg::A_START_HO: start_ho_r <= wword[15:0];
            ddc_chan_pkg::A_HOP_HO: hop_ho_r <= wword[15:0];
            ddc_chan_pkg::A_FREQ_LO: freq_lo_r <= wword[15:0];
            ddc_chan_pkg::A_FREQ_HI: freq_hi_r <= wword[15:0];
            ddc_chan_pkg::A_PHASE: phase_r <= wword[15:0];
            ddc_chan_pkg::A_OSC_CTL: osc_ctl_r <= wword[8:0];
            ddc_chan_pkg::A_RS_DEC: rs_dec_m1 <= wword[11:0];
            ddc_chan_pkg::A_RS_INT: rs_int_m1 <= wword[8:0];
            ddc_chan_pkg::A_RS_SCALE: rs_scale <= wword[11:0];
            ddc_chan_pkg::A_C5_DEC: c5_dec_m1 <= wword[7:0];
            ddc_chan_pkg::A_C5_SCALE: c5_scale <= wword[4:0];
            ddc_chan_pkg::A_CF_DEC: cf_dec_m1 <= wword[7:0];
            ddc_chan_pkg::A_CF_PHASE: cf_phase <= wword[7:0];
            ddc_chan_pkg::A_CF_TAPS: cf_taps_m1 <= wword[7:0];
            ddc_chan_pkg::A_CF_OFS: cf_offset <= wword[7:0];
            ddc_chan_pkg::A_CF_CTL: cf_ctl <= wword[10:0];
            default: ;
         endcase
      end
   end

   // Pin-sync copy from global write, then per-channel overwrite
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pin_r <= '0;
      end else if (ext_wr && ext_addr == ddc_chan_pkg::EXT_PIN_SYNC) begin
         pin_r <= {ext_wdata[ddc_chan_pkg::PIN_FIRST_BIT], ext_wdata[ddc_chan_pkg::PIN_HOP_BIT],
                   ext_wdata[ddc_chan_pkg::PIN_START_BIT]};
      end else if (int_wr && ia == ddc_chan_pkg::A_PIN) begin
         pin_r <= wword[2:0];
      end
   end

   // Sync sources
   assign soft_start = (int_wr && ia == ddc_chan_pkg::A_SOFT && wword[0]) ||
      (ext_wr && ext_addr == ddc_chan_pkg::EXT_SOFT_SYNC && ext_wdata[ddc_chan_pkg::SOFT_START_BIT]);
   assign soft_hop = (int_wr && ia == ddc_chan_pkg::A_SOFT && wword[1]) ||
      (ext_wr && ext_addr == ddc_chan_pkg::EXT_SOFT_SYNC && ext_wdata[ddc_chan_pkg::SOFT_HOP_BIT]);
   assign pin_pulse = sync_pins[osc_ctl_r.pin_sel] && !(pin_r.first_only && first_seen_r);
   assign pin_start = pin_pulse && pin_r.start_en;
   assign pin_hop = pin_pulse && pin_r.hop_en;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         first_seen_r <= 1'b0;
      else if (pin_start || pin_hop)
         first_seen_r <= 1'b1;
      else if (ext_wr && ext_addr == ddc_chan_pkg::EXT_PIN_SYNC)
         first_seen_r <= 1'b0;
   end

   holdoff_counter u_start (
      .mclk(mclk),
      .rst(rst),
      .trig(soft_start || pin_start),
      .load_val(start_ho_r),
      .fire(start_fire),
      .busy(start_busy)
   );
   holdoff_counter u_hop (
      .mclk(mclk),
      .rst(rst),
      .trig(soft_hop || pin_hop),
      .load_val(hop_ho_r),
      .fire(hop_fire),
      .busy(hop_busy)
   );

   // Sleep bit, start wakes or realigns
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sleep_r <= 1'b1;
         realign <= 1'b0;
      end else begin
         realign <= start_fire && !sleep_r;
         if (start_fire)
            sleep_r <= 1'b0;
         else if (ext_wr && ext_addr == ddc_chan_pkg::EXT_SLEEP_CTL)
            sleep_r <= ext_wdata[0];
         else if (int_wr && ia == ddc_chan_pkg::A_SLEEP)
            sleep_r <= wword[0];
      end
   end

   assign wake = sleep_r && (start_fire ||
      (ext_wr && ext_addr == ddc_chan_pkg::EXT_SLEEP_CTL && !ext_wdata[0]) ||
      (int_wr && ia == ddc_chan_pkg::A_SLEEP && !wword[0]));

   // Working frequency word transfer
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         freq_work_r <= 32'h0000_0000;
         osc <= '0;
      end else begin
         osc.load_freq <= 1'b0;
         osc.clr_acc <= 1'b0;
         if (hop_fire || wake) begin
            freq_work_r <= {freq_hi_r, freq_lo_r};
            osc.load_freq <= 1'b1;
            osc.clr_acc <= hop_fire && osc_ctl_r.clr_on_hop;
         end else if (hop_ho_r == ddc_chan_pkg::HO_ONE && int_wr &&
                      (ia == ddc_chan_pkg::A_FREQ_LO || ia == ddc_chan_pkg::A_FREQ_HI)) begin
            freq_work_r <= ia == ddc_chan_pkg::A_FREQ_LO ? {freq_hi_r, wword[15:0]}
                                                         : {wword[15:0], freq_lo_r};
            osc.load_freq <= 1'b1;
         end
         osc.freq <= freq_work_r;
         osc.phase <= phase_r;
         osc.ctl <= osc_ctl_r;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         channel_sleep <= 1'b1;
         portmap_access <= 1'b0;
      end else begin
         channel_sleep <= sleep_r;
         portmap_access <= sleep_ctl_r[ddc_chan_pkg::SLEEP_PORTMAP_BIT];
      end
   end

   a_wake_clears: assert property (@(posedge mclk) disable iff (rst)
      start_fire |=> !sleep_r)
      else $error("start did not wake channel");
   a_realign_run: assert property (@(posedge mclk) disable iff (rst)
      start_fire && !sleep_r |=> realign)
      else $error("running channel not realigned");
   a_hop_loads: assert property (@(posedge mclk) disable iff (rst)
      hop_fire |=> freq_work_r == $past({freq_hi_r, freq_lo_r}))
      else $error("hop did not load word");
   a_clear_acc: assert property (@(posedge mclk) disable iff (rst)
      hop_fire |=> osc.clr_acc == $past(osc_ctl_r.clr_on_hop))
      else $error("accumulator clear wrong");
   a_autoinc_ptr: assert property (@(posedge mclk) disable iff (rst)
      wr_low && acr_r[ddc_chan_pkg::ACR_AUTOINC_BIT] |=> car_r == $past(car_r) + 8'h01)
      else $error("pointer not incremented");
   a_top_nibble: assert property (@(posedge mclk) disable iff (rst)
      dr_top_r[7:4] == 4'h0)
      else $error("top register upper bits kept");
   a_first_only: assert property (@(posedge mclk) disable iff (rst)
      pin_r.first_only && first_seen_r |-> !pin_start && !pin_hop)
      else $error("repeat sync not blocked");
   a_sleep_mirror: assert property (@(posedge mclk) disable iff (rst)
      ext_wr && ext_addr == ddc_chan_pkg::EXT_SLEEP_CTL && !start_fire |=> sleep_r == $past(ext_wdata[0]))
      else $error("global sleep bit not mirrored");
   a_sleep_write: assert property (@(posedge mclk) disable iff (rst)
      int_wr && ia == ddc_chan_pkg::A_SLEEP && !start_fire |=> sleep_r == $past(wword[0]))
      else $error("channel sleep write lost");
   a_rs_commit: assert property (@(posedge mclk) disable iff (rst)
      int_wr && ia == ddc_chan_pkg::A_RS_DEC |=> rs_dec_m1 == $past(wword[11:0]))
      else $error("low data write did not commit");
   a_portmap_block: assert property (@(posedge mclk) disable iff (rst)
      wr_low && sleep_ctl_r[ddc_chan_pkg::SLEEP_PORTMAP_BIT] |=> $stable(c5_dec_m1) && $stable(cf_ctl))
      else $error("channel map written while redirected");
   a_top_read: assert property (@(posedge mclk) disable iff (rst)
      ext_rd && ext_addr == ddc_chan_pkg::EXT_DATA_TOP |=> ext_rdata[7:4] == 4'h0)
      else $error("top read upper bits not zero");
   a_mid_read: assert property (@(posedge mclk) disable iff (rst)
      ext_rd && ext_addr == ddc_chan_pkg::EXT_DATA_MID |=> ext_rdata == $past(rd_word_r[15:8]))
      else $error("mid read wrong byte");
   a_pin_copy: assert property (@(posedge mclk) disable iff (rst)
      ext_wr && ext_addr == ddc_chan_pkg::EXT_PIN_SYNC |=>
      pin_r == $past(ext_wdata[ddc_chan_pkg::PIN_FIRST_BIT:ddc_chan_pkg::PIN_START_BIT]))
      else $error("pin sync bits not copied");
   a_pin_quiet: assert property (@(posedge mclk) disable iff (rst)
      int_wr && ia == ddc_chan_pkg::A_PIN && !start_busy && sync_pins == 4'h0 |=> !start_busy)
      else $error("pin enable write triggered start");
   a_wake_loads: assert property (@(posedge mclk) disable iff (rst)
      wake |=> freq_work_r == $past({freq_hi_r, freq_lo_r}))
      else $error("wake did not load word");
   a_shadow_hold: assert property (@(posedge mclk) disable iff (rst)
      int_wr && ia == ddc_chan_pkg::A_FREQ_LO && hop_ho_r != ddc_chan_pkg::HO_ONE && !hop_fire && !wake
      |=> $stable(freq_work_r))
      else $error("shadow write reached working word");
   a_ctl_follows: assert property (@(posedge mclk) disable iff (rst)
      osc.ctl == $past(osc_ctl_r))
      else $error("control bits not forwarded");
   a_no_realign_asleep: assert property (@(posedge mclk) disable iff (rst)
      start_fire && sleep_r |=> !realign)
      else $error("realign while asleep");
   a_clr_only_hop: assert property (@(posedge mclk) disable iff (rst)
      !hop_fire |=> !osc.clr_acc)
      else $error("accumulator cleared without hop");
   a_start_zero: assert property (@(posedge mclk) disable iff (rst)
      soft_start && start_ho_r == ddc_chan_pkg::HO_ZERO && !start_busy |=> !start_fire)
      else $error("start hold-off zero fired");
   a_hop_zero: assert property (@(posedge mclk) disable iff (rst)
      soft_hop && hop_ho_r == ddc_chan_pkg::HO_ZERO && !hop_busy |=> !hop_fire)
      else $error("hop hold-off zero fired");
   a_freq_out: assert property (@(posedge mclk) disable iff (rst)
      osc.load_freq |=> osc.freq == $past(freq_work_r))
      else $error("frequency output stale");
   a_autoinc_read: assert property (@(posedge mclk) disable iff (rst)
      rd_low && acr_r[ddc_chan_pkg::ACR_AUTOINC_BIT] |=> car_r == $past(car_r) + 8'h01)
      else $error("pointer not incremented on read");
   c_soft_start: cover property (@(posedge mclk) disable iff (rst) soft_start ##[1:20] start_fire);
   c_hop: cover property (@(posedge mclk) disable iff (rst) pin_hop ##[1:20] hop_fire);
   c_realign: cover property (@(posedge mclk) disable iff (rst) realign);
   c_pin_start: cover property (@(posedge mclk) disable iff (rst) pin_start ##1 start_fire);
   c_wake_load: cover property (@(posedge mclk) disable iff (rst) wake ##1 osc.load_freq);
endmodule : ddc_channel_sync_control
`default_nettype wire

/* File: bench/host_model.sv */
`default_nettype none
module host_model (
   input wire logic mclk,
   output logic [2:0] ext_addr,
   output logic [7:0] ext_wdata,
   output logic ext_wr,
   output logic ext_rd,
   input wire logic [7:0] ext_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      ext_addr = 3'h0;
      ext_wdata = 8'h00;
      ext_wr = 1'b0;
      ext_rd = 1'b0;
   end
   // Data lines show the inverse once released
   task automatic ext_write(input logic [2:0] a, input logic [7:0] d);
      @(negedge mclk);
      ext_addr = a;
      ext_wdata = d;
      ext_wr = 1'b1;
      @(negedge mclk);
      ext_wr = 1'b0;
      ext_wdata = ~d;
   endtask : ext_write
   task automatic ext_read(input logic [2:0] a, output logic [7:0] d);
      @(negedge mclk);
      ext_addr = a;
      ext_rd = 1'b1;
      @(negedge mclk);
      ext_rd = 1'b0;
      @(negedge mclk);
      d = ext_rdata;
   endtask : ext_read
   // Upper bytes first, low byte commits
   task automatic data_write(input logic [19:0] w);
      ext_write(ddc_chan_pkg::EXT_DATA_MID, w[15:8]);
      ext_write(ddc_chan_pkg::EXT_DATA_TOP, {4'h0, w[19:16]});
      ext_write(ddc_chan_pkg::EXT_DATA_LOW, w[7:0]);
   endtask : data_write
   task automatic reg_write(input logic [7:0] ca, input logic [19:0] w);
      ext_write(ddc_chan_pkg::EXT_CHAN_ADDR, ca);
      data_write(w);
   endtask : reg_write
   // Low byte read first starts the fetch
   task automatic reg_read(input logic [7:0] ca, output logic [7:0] mid, output logic [7:0] top);
      logic [7:0] lo;
      ext_write(ddc_chan_pkg::EXT_CHAN_ADDR, ca);
      ext_read(ddc_chan_pkg::EXT_DATA_LOW, lo);
      ext_read(ddc_chan_pkg::EXT_DATA_MID, mid);
      ext_read(ddc_chan_pkg::EXT_DATA_TOP, top);
   endtask : reg_read
endmodule : host_model
`default_nettype wire

/* File: bench/testbench.sv */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk;
   logic rst;
   logic [2:0] ext_addr;
   logic [7:0] ext_wdata;
   logic ext_wr;
   logic ext_rd;
   logic [7:0] ext_rdata;
   logic [3:0] sync_pins;
   logic channel_sleep;
   logic realign;
   logic portmap_access;
   ddc_chan_pkg::osc_out_t osc;
   logic [11:0] rs_dec_m1;
   logic [8:0] rs_int_m1;
   logic [7:0] c5_dec_m1;
   logic [4:0] c5_scale;
   logic [7:0] cf_taps_m1;
   logic [7:0] cf_offset;
   logic [10:0] cf_ctl;
   int miscompares = 0;
   int check_count = 0;
   ddc_channel_sync_control i_ddc_channel_sync_control (.mclk(mclk), .rst(rst), .ext_addr(ext_addr),
      .ext_wdata(ext_wdata), .ext_wr(ext_wr), .ext_rd(ext_rd), .ext_rdata(ext_rdata), .sync_pins(sync_pins),
      .channel_sleep(channel_sleep), .realign(realign), .portmap_access(portmap_access), .osc(osc),
      .rs_dec_m1(rs_dec_m1), .rs_int_m1(rs_int_m1), .rs_scale(), .c5_dec_m1(c5_dec_m1), .c5_scale(c5_scale),
      .cf_dec_m1(), .cf_phase(), .cf_taps_m1(cf_taps_m1), .cf_offset(cf_offset), .cf_ctl(cf_ctl));
   host_model i_host_model (.mclk(mclk), .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_wr(ext_wr),
      .ext_rd(ext_rd), .ext_rdata(ext_rdata));
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [19:0] w);
      i_host_model.reg_write(a, w);
   endtask : wr
   task automatic ex(input logic [2:0] a, input logic [7:0] d);
      i_host_model.ext_write(a, d);
   endtask : ex
   // Collects clr_acc, load_freq, realign, awake over eight cycles
   task automatic watch(output logic [3:0] s);
      s = 4'h0;
      repeat (8) begin
         @(negedge mclk);
         s = s | {osc.clr_acc, osc.load_freq, realign, ~channel_sleep};
      end
   endtask : watch
   task automatic pulse(input logic [3:0] p);
      @(negedge mclk);
      sync_pins = p;
      @(negedge mclk);
      sync_pins = 4'h0;
   endtask : pulse
   task automatic t_regs;
      logic [7:0] m;
      logic [7:0] t;
      check(channel_sleep, 1'b1);
      wr(8'h90, 20'h00abc);
      wr(8'h91, 20'h001ff);
      wr(8'h88, 20'h00047);
      check(rs_dec_m1, 12'habc);
      check(rs_int_m1, 9'h1ff);
      @(negedge mclk);
      check(osc.ctl, 9'h047);
      ex(3'h6, 8'h10);
      ex(3'h1, 8'hbc);
      ex(3'h2, 8'hf5);
      ex(3'h0, 8'h3c);
      wr(8'ha4, 20'h00100);
      wr(8'h10, 20'h12345);
      check(cf_ctl, 11'h100);
      i_host_model.reg_read(8'h10, m, t);
      check({t, m}, 16'h0123);
      wr(8'ha4, 20'h00000);
      i_host_model.reg_read(8'h10, m, t);
      check({t, m}, 16'h05bc);
   endtask : t_regs
   task automatic t_autoinc;
      ex(3'h7, 8'h80);
      ex(3'h6, 8'h94);
      i_host_model.data_write(20'h00012);
      i_host_model.data_write(20'h00007);
      ex(3'h7, 8'h00);
      check(c5_dec_m1, 8'h12);
      check(c5_scale, 5'h07);
      wr(8'ha2, 20'h0009f);
      wr(8'ha3, 20'h00020);
      check(cf_taps_m1, 8'h9f);
      check(cf_offset, 8'h20);
   endtask : t_autoinc
   task automatic t_start;
      logic [3:0] s;
      wr(8'h83, 20'h00000);
      ex(3'h5, 8'h11);
      watch(s);
      check(s[0], 1'b0);
      wr(8'h83, 20'h00003);
      ex(3'h5, 8'h11);
      repeat (3) @(negedge mclk);
      check(channel_sleep, 1'b1);
      @(negedge mclk);
      check(channel_sleep, 1'b0);
      watch(s);
      check(channel_sleep, 1'b0);
      wr(8'h83, 20'h00002);
      wr(8'h81, 20'h00001);
      watch(s);
      check(s[1], 1'b1);
   endtask : t_start
   task automatic t_hop;
      logic [3:0] s;
      wr(8'h84, 20'h00003);
      wr(8'h85, 20'h05678);
      wr(8'h86, 20'h01234);
      check(osc.freq, 32'h00000000);
      ex(3'h5, 8'h21);
      watch(s);
      check(s[2], 1'b1);
      check(osc.freq, 32'h12345678);
      wr(8'h84, 20'h00000);
      wr(8'h85, 20'h01111);
      ex(3'h5, 8'h21);
      watch(s);
      check(s[2], 1'b0);
      check(osc.freq, 32'h12345678);
      wr(8'h84, 20'h00001);
      wr(8'h85, 20'h01111);
      repeat (3) @(negedge mclk);
      check(osc.freq, 32'h12341111);
      wr(8'h88, 20'h00008);
      ex(3'h5, 8'h21);
      watch(s);
      check(s[3:2], 2'h3);
   endtask : t_hop
   task automatic t_pin;
      logic [3:0] s;
      ex(3'h3, 8'h01);
      @(negedge mclk);
      check(channel_sleep, 1'b1);
      wr(8'h80, 20'h00000);
      @(negedge mclk);
      check(channel_sleep, 1'b0);
      ex(3'h4, 8'h50);
      ex(3'h3, 8'h01);
      wr(8'h83, 20'h00001);
      wr(8'h88, 20'h00080);
      pulse(4'h1);
      watch(s);
      check(s[0], 1'b0);
      pulse(4'h2);
      watch(s);
      check(s[0], 1'b1);
      wr(8'h80, 20'h00001);
      pulse(4'h2);
      watch(s);
      check(s[0], 1'b0);
      ex(3'h4, 8'h20);
      pulse(4'h2);
      watch(s);
      check(s[2], 1'b1);
      check(s[0], 1'b0);
   endtask : t_pin
   task automatic t_portmap;
      ex(3'h3, 8'h20);
      @(negedge mclk);
      check(portmap_access, 1'b1);
      wr(8'h94, 20'h00099);
      check(c5_dec_m1, 8'h12);
      ex(3'h3, 8'h00);
      @(negedge mclk);
      check(portmap_access, 1'b0);
   endtask : t_portmap
   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : conclude
   initial begin
      rst = 1'b1;
      sync_pins = 4'h0;
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      rst = 1'b0;
      t_regs();
      t_autoinc();
      t_start();
      t_hop();
      t_pin();
      t_portmap();
      conclude();
   end
   // The sequence needs well under a thousand cycles
   initial begin
      repeat (3000) @(posedge mclk);
      miscompares++;
      conclude();
   end
endmodule : testbench
`default_nettype wire
